// File: rtl/ptc_pkg.sv
// package: register map, field layout and types of the paired timer
package ptc_pkg;

    localparam int unsigned PTC_ADDR_W = 4;

    // byte offsets on the bus
    localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CONTROL = 4'h0;
    localparam logic [PTC_ADDR_W-1:0] PTC_OFF_COUNT   = 4'h4;
    localparam logic [PTC_ADDR_W-1:0] PTC_OFF_PERIOD  = 4'h8;

    // control field positions
    localparam int unsigned PTC_BIT_RUN       = 15;
    localparam int unsigned PTC_BIT_IDLE_HALT = 13;
    localparam int unsigned PTC_BIT_GATE      = 6;
    localparam int unsigned PTC_BIT_PS_HI     = 5;
    localparam int unsigned PTC_BIT_PS_LO     = 4;
    localparam int unsigned PTC_BIT_PAIR      = 3;
    localparam int unsigned PTC_BIT_CLK_SRC   = 1;

    // implemented control bits, all others read zero
    localparam logic [15:0] PTC_CONTROL_MASK  = 16'ha07a;
    localparam logic [15:0] PTC_CONTROL_RESET = 16'h0000;
    localparam logic [31:0] PTC_PERIOD_RESET  = 32'hffff_ffff;

    // prescale codes and terminal counts (ratio minus one)
    localparam logic [1:0] PTC_PS_1   = 2'h0;
    localparam logic [1:0] PTC_PS_8   = 2'h1;
    localparam logic [1:0] PTC_PS_64  = 2'h2;
    localparam logic [1:0] PTC_PS_256 = 2'h3;
    localparam logic [7:0] PTC_TC_1   = 8'h00;
    localparam logic [7:0] PTC_TC_8   = 8'h07;
    localparam logic [7:0] PTC_TC_64  = 8'h3f;
    localparam logic [7:0] PTC_TC_256 = 8'hff;

    typedef struct packed {
        logic       timer_run;
        logic       idle_halt;
        logic       gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic       pair_wide_mode;
        logic       clock_source_select;
    } ptc_control_t;

    function automatic ptc_control_t ptc_unpack(input logic [15:0] w);
        ptc_control_t c;
        c.timer_run              = w[PTC_BIT_RUN];
        c.idle_halt              = w[PTC_BIT_IDLE_HALT];
        c.gate_accumulate_enable = w[PTC_BIT_GATE];
        c.prescale_select        = w[PTC_BIT_PS_HI:PTC_BIT_PS_LO];
        c.pair_wide_mode         = w[PTC_BIT_PAIR];
        c.clock_source_select    = w[PTC_BIT_CLK_SRC];
        return c;
    endfunction

endpackage

// File: rtl/ptc_prescaler.sv
// prescaler turning count events into one-cycle ticks
`timescale 1ns/1ps
module ptc_prescaler
    import ptc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,
    input  wire logic       event_i,
    input  wire logic [1:0] prescale_select_i,
    output logic            tick_o
);

    logic [7:0] div;
    logic [7:0] next_div;
    logic [7:0] terminal;

    always_comb begin
        unique case (prescale_select_i)
            PTC_PS_1:   terminal = PTC_TC_1;
            PTC_PS_8:   terminal = PTC_TC_8;
            PTC_PS_64:  terminal = PTC_TC_64;
            PTC_PS_256: terminal = PTC_TC_256;
        endcase
    end

    // a shrinking ratio could strand div above terminal, so compare >=
    assign tick_o = event_i && (div >= terminal);

    always_comb begin
        next_div = div;
        if (clear_i) begin
            next_div = 8'h00;
        end else if (tick_o) begin
            next_div = 8'h00;
        end else if (event_i) begin
            next_div = div + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= 8'h00;
        end else begin
            div <= next_div;
        end
    end

endmodule // ptc_prescaler

// File: rtl/ptc_timer.sv
// paired 16/32-bit timer with control register on a wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module ptc_timer
    import ptc_pkg::*;
#(
    parameter int unsigned HALF_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // device and pins
    input  wire logic        idle_mode_i,
    input  wire logic        external_count_pin_i,
    input  wire logic        gate_i,
    output logic             period_match_o,
    output logic             pair_wide_mode_o
);

    initial begin
        if (HALF_W != 16) begin
            $error("ptc_timer: HALF_W must be 16");
        end
    end

    localparam int unsigned FULL_W = 2 * HALF_W;

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [15:0]       control;
    logic [15:0]       next_control;
    logic [FULL_W-1:0] period;
    logic [FULL_W-1:0] next_period;
    logic [FULL_W-1:0] count;
    logic [FULL_W-1:0] next_count;
    logic              ack;
    logic              next_ack;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;
    ptc_control_t      ctl;

    assign ctl = ptc_unpack(control);

    function automatic logic [31:0] ptc_merge(input logic [31:0] old,
                                              input logic [31:0] wr,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic req;
    logic wr_ctl;
    logic wr_cnt;
    logic wr_per;
    logic [31:0] ctl_merged;
    logic [31:0] cnt_merged;
    logic [31:0] per_merged;

    assign req    = wb_cyc_i && wb_stb_i && !ack;
    assign wr_ctl = req && wb_we_i && (wb_adr_i == PTC_OFF_CONTROL);
    assign wr_cnt = req && wb_we_i && (wb_adr_i == PTC_OFF_COUNT);
    assign wr_per = req && wb_we_i && (wb_adr_i == PTC_OFF_PERIOD);
    assign ctl_merged = ptc_merge({16'h0000, control}, wb_dat_i, wb_sel_i);
    assign cnt_merged = ptc_merge(32'(count), wb_dat_i, wb_sel_i);
    assign per_merged = ptc_merge(32'(period), wb_dat_i, wb_sel_i);

    always_comb begin
        next_ack    = req;
        next_rdata  = 32'h0000_0000;
        next_control = control;
        next_period  = period;
        if (wr_ctl) begin
            next_control = ctl_merged[15:0] & PTC_CONTROL_MASK;
        end
        if (wr_per) begin
            next_period = per_merged[FULL_W-1:0];
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                PTC_OFF_CONTROL: next_rdata = {16'h0000, control};
                PTC_OFF_COUNT:   next_rdata = 32'(count);
                PTC_OFF_PERIOD:  next_rdata = 32'(period);
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control  <= PTC_CONTROL_RESET;
            period   <= PTC_PERIOD_RESET;
            ack      <= 1'b0;
            rdata    <= 32'h0000_0000;
        end else begin
            control  <= next_control;
            period   <= next_period;
            ack      <= next_ack;
            rdata    <= next_rdata;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    ////////////////////////////////////////////////////////////////////////
    // count source

    logic pin_q;
    logic next_pin_q;
    logic pin_rise;
    logic halted;
    logic gating;
    logic src_event;
    logic tick;

    assign next_pin_q = external_count_pin_i;
    assign pin_rise   = external_count_pin_i && !pin_q;

    // idle halt wins over every count source while the device idles
    assign halted = ctl.idle_halt && idle_mode_i;
    assign gating = ctl.gate_accumulate_enable
                    && !ctl.clock_source_select;

    always_comb begin
        src_event = 1'b0;
        if (ctl.timer_run && !halted) begin
            if (ctl.clock_source_select) begin
                src_event = pin_rise;
            end else if (gating) begin
                src_event = gate_i;
            end else begin
                src_event = 1'b1;
            end
        end
    end

    ptc_prescaler u_prescaler (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .clear_i           (!ctl.timer_run),
        .event_i           (src_event),
        .prescale_select_i (ctl.prescale_select),
        .tick_o            (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // counter: low half always, high half only when paired

    logic              match;
    logic              match_q;
    logic              next_match_q;
    logic [HALF_W-1:0] lo_inc;

    assign lo_inc = count[HALF_W-1:0] + HALF_W'(1);

    // narrow mode compares only the low half; period restarts at zero
    assign match = ctl.pair_wide_mode
                   ? (count == period)
                   : (count[HALF_W-1:0] == period[HALF_W-1:0]);

    always_comb begin
        next_count   = count;
        next_match_q = 1'b0;
        if (wr_cnt) begin
            next_count = cnt_merged[FULL_W-1:0];
        end else if (tick) begin
            next_match_q = match;
            if (ctl.pair_wide_mode) begin
                next_count = match ? '0 : count + FULL_W'(1);
            end else begin
                next_count[HALF_W-1:0] = match ? '0 : lo_inc;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count   <= '0;
            match_q <= 1'b0;
            pin_q   <= 1'b0;
        end else begin
            count   <= next_count;
            match_q <= next_match_q;
            pin_q   <= next_pin_q;
        end
    end

    assign period_match_o   = match_q;
    assign pair_wide_mode_o = ctl.pair_wide_mode;

endmodule // ptc_timer

// File: test/ptc_timer_asserts.sv
// checker: bus answer and pairing properties of the paired timer
`timescale 1ns/1ps
module ptc_timer_asserts (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        idle_mode_i,
    input  wire logic        external_count_pin_i,
    input  wire logic        gate_i,
    input  wire logic        period_match_o,
    input  wire logic        pair_wide_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_one: assert property (p_one) else $error("ack too long");
    property p_quiet; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("data idle");
    property p_rsv; wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h0
        |-> (wb_dat_o & 32'hffff5f85) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_unmap; wb_ack_o && !$past(wb_we_i)
        && !($past(wb_adr_i) inside {4'h0, 4'h4, 4'h8})
        |-> wb_dat_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    // pair output is the control flop itself with no extra lag, so it is new one on; look two on
    property p_pair; wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == 4'h0 && wb_sel_i[0]
        |-> ##2 pair_wide_mode_o == $past(wb_dat_i[3], 2); endproperty
    a_pair: assert property (p_pair) else $error("pair not set");
    property p_hold; $changed(pair_wide_mode_o)
        |-> wb_ack_o || $past(wb_ack_o); endproperty
    a_hold: assert property (p_hold) else $error("pair moved");
    // explicit disable overrides the default, which would mask this one
    property p_rst; disable iff (1'b0) rst_i
        |=> !wb_ack_o && !pair_wide_mode_o && !period_match_o; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule // ptc_timer_asserts

// File: test/ptc_pin_model.sv
// far-side model: external count pin as a gated square wave
`timescale 1ns/1ps
module ptc_pin_model (
    input  wire logic clk_i,
    input  wire logic en_i,
    output logic      pin_o
);
    logic [1:0] div = 2'h0;
    initial pin_o = 1'b0;
    // one rising edge every 8 clocks; held low when idle
    always @(posedge clk_i) begin
        div <= en_i ? div + 2'h1 : 2'h0;
        if (!en_i)
            pin_o <= 1'b0;
        else if (div == 2'h3)
            pin_o <= ~pin_o;
    end
endmodule // ptc_pin_model

// File: test/test_paired_timer_control.sv
// testbench: registers, prescale, idle, gate, source and pairing
`timescale 1ns/1ps
module test_paired_timer_control;
    import ptc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic        idle = 0, gate = 0, ext_en = 0, pin, ack, match, pair;
    logic [3:0]  adr = 0;
    logic [31:0] dat = 0, dout, q, q0;
    int          failures = 0, n_checks = 0, n_match = 0;
    always #12.5 clk_i = ~clk_i;
    ptc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .idle_mode_i(idle), .external_count_pin_i(pin), .gate_i(gate),
        .period_match_o(match), .pair_wide_mode_o(pair));
    ptc_pin_model far (.clk_i(clk_i), .en_i(ext_en), .pin_o(pin));
    // tally of period match pulses, one per cycle seen high
    always @(posedge clk_i) if (match === 1'b1) n_match++;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t = 0;
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++t < 20);
        if (t == 20) begin
            failures++;
            wrap_up;
        end
        q = dout;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    // spans are loose by a few cycles: bus latency is not the point here
    function automatic logic [31:0] near(input logic [31:0] g, input int e);
        return {31'h0, (g + 3 >= e) && (g <= e + 3)};
    endfunction
    function automatic int ratio(input logic [1:0] ps);
        return ps == 2'h3 ? 256 : ps == 2'h2 ? 64 : ps == 2'h1 ? 8 : 1;
    endfunction
    task automatic run(input logic [15:0] c, input logic [31:0] s, input int n);
        wb(1, PTC_OFF_COUNT, s);
        wb(1, PTC_OFF_CONTROL, {16'h0, c});
        repeat (n) @(posedge clk_i);
        wb(1, PTC_OFF_CONTROL, 32'h0);
        wb(0, PTC_OFF_COUNT, 32'h0);
    endtask
    task automatic wrap_up;
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        int m0;
        void'($urandom(32'h2e30da91));
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        wb(0, PTC_OFF_CONTROL, 0);
        chk("control", q, 0);
        wb(0, PTC_OFF_COUNT, 0);
        chk("count", q, 0);
        wb(0, PTC_OFF_PERIOD, 0);
        chk("period", q, 32'hffffffff);
        wb(0, 4'hc, 0);
        chk("unmapped", q, 0);
        repeat (4) begin
            n = $urandom;
            wb(1, PTC_OFF_CONTROL, n);
            wb(0, PTC_OFF_CONTROL, 0);
            chk("control", q, n & 32'ha07a);
        end
        for (int i = 0; i < 4; i++) begin
            n = 300 + $urandom % 300;
            run(16'h8000 | 16'(i << 4), 0, n);
            chk("prescale", near(q, (n + 3) / ratio(2'(i))), 1);
        end
        q0 = q;
        repeat (50) @(posedge clk_i);
        wb(0, PTC_OFF_COUNT, 0);
        chk("stopped", q, q0);
        idle <= 1;
        run(16'ha000, 0, 200);
        chk("idle halt", q, 0);
        run(16'h8000, 0, 200);
        chk("idle run", near(q, 203), 1);
        idle <= 0;
        run(16'h8040, 0, 200);
        chk("gate low", q, 0);
        gate <= 1;
        run(16'h8040, 0, 200);
        chk("gate high", near(q, 203), 1);
        gate <= 0;
        ext_en <= 1;
        run(16'h8042, 0, 400);
        chk("external", near(q, 403 / 8), 1);
        ext_en <= 0;
        run(16'h8008, 32'hfff0, 100);
        chk("pair high", q[31:16], 1);
        run(16'h8000, 32'hfff0, 100);
        chk("split high", q[31:16], 0);
        wb(1, PTC_OFF_CONTROL, 32'h8);
        chk("pair out", {31'h0, pair}, 1);
        wb(1, PTC_OFF_PERIOD, 32'h9);
        m0 = n_match;
        run(16'h8008, 0, 100);
        chk("wrap", q, 32'(103 % 10));
        chk("matches", 32'(n_match - m0), 10);
        chk("pair off", {31'h0, pair}, 0);
        wrap_up;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        wrap_up;
    end
endmodule // test_paired_timer_control
bind ptc_timer ptc_timer_asserts chk_u (.*);
